// ---- logic/osc_ctrl.v ----
/*
 * Oscillator switch and trim control: APB register slave, clock group
 * switch sequencer, PLL lock and clock fail status, configuration freeze
 * and fast RC trim selection (base, roll sequence or pseudo-random dither).
 * Assumes all inputs are synchronous to clk_sys_in and that the clock
 * multiplexer outside follows clk_sel_out.
 */
// Our own choices: the register addresses and the APB slave port.
// What this block does
// R1 - Read-only current group at bits 14-12
// R2 - Reset forces current group to fast RC
// R3 - Successful switch copies next into current group
// R4 - Monitor failure sets current group to RC
// R5 - Writable next group field at bits 10-8
// R6 - Freeze plus config bit blocks clock changes
// R7 - Freeze bit sticks until reset
// R8 - Lock status set, cleared by loss/switch/reset
// R9 - Lock reads zero unless PLL group selected
// R10 - Bit 4 enables pseudo-random dither
// R11 - Clock fail flag readable and software clearable
// R12 - Fail flag set on failure, cleared on switch
// R13 - Sequencer picks trim field by roll input
// R14 - Sequencer and dither off use base trim only
// R15 - Roll N selects sequence trim field N
// R16 - Trim is a signed step around centre
// R17 - Switch request set by software, cleared after switch
// R18 - Request cleared on redundant switch or failure
// R19 - Writable 15-bit pseudo-random trim value
// R20 - Unimplemented bits ignore writes, read zero
// R21 - Starting group from configuration bits when switching enabled
// R22 - Control byte writes need two unlock bytes first
// R23 - Decode switching and monitor configuration
// R24 - Keep old clock until new source ready
`timescale 1ns/100ps
`include "osc_defs.vh"

module osc_ctrl
(
   // Clock and reset
   input  wire        clk_sys_in,
   input  wire        sys_rst_in,
   // APB slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   input  wire [3:0]  pstrb_in,
   output wire        pready_out,
   output reg  [31:0] prdata_out,
   output wire        pslverr_out,
   // Configuration bits
   input  wire [1:0]  cfg_initial_group_in,
   input  wire [1:0]  switch_monitor_config_in,
   // Oscillator status
   input  wire        new_source_ready_in,
   input  wire        pll_lock_in,
   input  wire        clock_fail_in,
   input  wire [2:0]  roll_in,
   // Clock control
   output reg  [2:0]  clk_sel_out,
   output reg  [2:0]  target_group_out,
   output reg         source_start_out,
   output reg         clk_change_out,
   // Fast RC trim
   output reg  [3:0]  fast_rc_trim_out,
   output reg  [4:0]  trim_step_out
);

   // -------------------------------------------------------------------
   // Switch sequencer states
   // -------------------------------------------------------------------
   localparam [2:0] ST_IDLE   = 3'h1;
   localparam [2:0] ST_WAIT   = 3'h2;
   localparam [2:0] ST_CHANGE = 3'h4;

   // Unlock states
   localparam [1:0] UL_IDLE  = 2'h0;
   localparam [1:0] UL_FIRST = 2'h1;
   localparam [1:0] UL_ARMED = 2'h2;

   // -------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------
   // Signed step, sign-extended: 0000 centre, 0111 max, 1000 min
   function [4:0] trim_step;
      input [3:0] t;
      begin
         trim_step = {t[3], t}; // see R16
      end
   endfunction

   // Unlock sequence step for one byte lane
   function [1:0] unlock_next;
      input [1:0] st;
      input [7:0] d;
      input [7:0] k1;
      input [7:0] k2;
      begin
         if (st == UL_ARMED)
            unlock_next = UL_IDLE;
         else if (d == k1)
            unlock_next = UL_FIRST;
         else if ((st == UL_FIRST) && (d == k2))
            unlock_next = UL_ARMED;
         else
            unlock_next = UL_IDLE;
      end
   endfunction

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   reg  [2:0]  cur_grp_ff;
   reg  [2:0]  nxt_grp_ff;
   reg         freeze_ff;
   reg         lock_ff;
   reg         dither_ff;
   reg         fail_ff;
   reg         tseq_ff;
   reg         swreq_ff;
   reg  [15:0] tuning_ff;
   reg  [15:0] tuning_up_ff;
   reg  [14:0] prtrim_ff;
   reg  [2:0]  state_ff;
   reg  [1:0]  ul_lo_ff;
   reg  [1:0]  ul_hi_ff;
   reg         boot_ff;

   reg  [2:0]  nxt_state;
   reg  [31:0] nxt_rdata;
   reg  [3:0]  sel_trim;

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   wire setup_ph   = psel_in & ~penable_in;
   wire access_ph  = psel_in & penable_in;
   wire hit_ctrl   = (paddr_in == `OSC_OFF_CONTROL);
   wire hit_tun    = (paddr_in == `OSC_OFF_TUNING);
   wire hit_tun_up = (paddr_in == `OSC_OFF_TUNING_UP);
   wire hit_prt    = (paddr_in == `OSC_OFF_PRTRIM);
   wire mapped     = hit_ctrl | hit_tun | hit_tun_up | hit_prt;
   wire wr_go      = access_ph & pwrite_in & mapped;
   wire lo_byte_wr = access_ph & pwrite_in & hit_ctrl & (pstrb_in == 4'h1);
   wire hi_byte_wr = access_ph & pwrite_in & hit_ctrl & (pstrb_in == 4'h2);
   wire lo_commit  = lo_byte_wr & (ul_lo_ff == UL_ARMED); // see R22
   wire hi_commit  = hi_byte_wr & (ul_hi_ff == UL_ARMED); // see R22

   assign pready_out  = 1'b1;
   assign pslverr_out = access_ph & ~mapped;

   // -------------------------------------------------------------------
   // Configuration decode
   // -------------------------------------------------------------------
   wire sw_enabled  = ~switch_monitor_config_in[1];                     // see R23
   wire mon_enabled = (switch_monitor_config_in == 2'h0);               // see R23
   wire frozen      = freeze_ff & switch_monitor_config_in[1];          // see R6
   wire fail_event  = clock_fail_in & mon_enabled;

   // Sequencer decisions
   wire idle       = (state_ff == ST_IDLE);
   wire redundant  = idle & swreq_ff & ~boot_ff & (nxt_grp_ff == cur_grp_ff);
   wire bad_req    = idle & swreq_ff & ~boot_ff & (~sw_enabled | nxt_grp_ff[2]); // see R5
   wire start_sw   = idle & swreq_ff & ~boot_ff & ~redundant & ~bad_req & ~fail_event;
   wire pll_target = target_group_out[0];
   wire src_ready  = new_source_ready_in & (~pll_target | pll_lock_in);  // see R24
   wire done_sw    = (state_ff == ST_CHANGE) & ~fail_event;

   // -------------------------------------------------------------------
   // Switch state machine
   // -------------------------------------------------------------------
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (start_sw)
               nxt_state = ST_WAIT;
         ST_WAIT:
            if (fail_event)
               nxt_state = ST_IDLE;
            else if (src_ready)
               nxt_state = ST_CHANGE;                                    // see R24
         ST_CHANGE:
            nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         state_ff         <= ST_IDLE;
         cur_grp_ff       <= `OSC_GRP_FRC;                               // see R2
         clk_sel_out      <= `OSC_GRP_FRC;
         target_group_out <= `OSC_GRP_FRC;
         source_start_out <= 1'b0;
         clk_change_out   <= 1'b0;
      end
      else
      begin
         state_ff       <= nxt_state;
         clk_change_out <= done_sw;
         if (start_sw)
         begin
            target_group_out <= nxt_grp_ff;
            source_start_out <= 1'b1;
         end
         else if (done_sw | fail_event)
            source_start_out <= 1'b0;
         if (fail_event)
         begin
            cur_grp_ff  <= `OSC_GRP_FRC;                                 // see R4
            clk_sel_out <= `OSC_GRP_FRC;
         end
         else if (done_sw)
         begin
            cur_grp_ff  <= target_group_out;                             // see R3
            clk_sel_out <= target_group_out;                             // see R24
         end
      end
   end

   // -------------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------------
   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         nxt_grp_ff <= `OSC_GRP_FRC;
         freeze_ff  <= 1'b0;
         lock_ff    <= 1'b0;
         dither_ff  <= 1'b0;
         fail_ff    <= 1'b0;
         tseq_ff    <= 1'b0;
         swreq_ff   <= 1'b0;
         ul_lo_ff   <= UL_IDLE;
         ul_hi_ff   <= UL_IDLE;
         boot_ff    <= 1'b1;
      end
      else
      begin
         boot_ff <= 1'b0;
         // Unlock trackers: any other transfer breaks the sequence
         if (lo_byte_wr)
            ul_lo_ff <= unlock_next(ul_lo_ff, pwdata_in[7:0],
                                    `OSC_UNLK_LO_1, `OSC_UNLK_LO_2);     // see R22
         else if (access_ph)
            ul_lo_ff <= UL_IDLE;
         if (hi_byte_wr)
            ul_hi_ff <= unlock_next(ul_hi_ff, pwdata_in[15:8],
                                    `OSC_UNLK_HI_1, `OSC_UNLK_HI_2);     // see R22
         else if (access_ph)
            ul_hi_ff <= UL_IDLE;

         // Starting group from configuration, switched in after reset when switching enabled
         if (boot_ff)
         begin
            nxt_grp_ff <= {1'b0, cfg_initial_group_in};                  // see R21
            swreq_ff   <= (cfg_initial_group_in != 2'h0);                // see R21
         end
         else
         begin
            if (hi_commit & ~frozen)
               nxt_grp_ff <= pwdata_in[`OSC_NXT_HI:`OSC_NXT_LO];         // see R5
            // Hardware clears take priority over a software set
            if (done_sw | redundant | bad_req | fail_event)
               swreq_ff <= 1'b0;                                         // see R17, R18
            else if (lo_commit & ~frozen)
               swreq_ff <= pwdata_in[`OSC_SWREQ_BIT];                    // see R17
         end

         if (lo_commit)
         begin
            if (pwdata_in[`OSC_FREEZE_BIT])
               freeze_ff <= 1'b1;                                        // see R7
            dither_ff <= pwdata_in[`OSC_DITHER_BIT];                     // see R10
            if (~frozen)
               tseq_ff <= pwdata_in[`OSC_TSEQ_BIT];
         end

         // Fail flag: set wins over software clear and switch start
         if (fail_event)
            fail_ff <= 1'b1;                                             // see R12
         else if (start_sw)
            fail_ff <= 1'b0;                                             // see R12
         else if (lo_commit & ~pwdata_in[`OSC_FAIL_BIT])
            fail_ff <= 1'b0;                                             // see R11

         // PLL lock status
         if (start_sw | ~pll_lock_in)
            lock_ff <= 1'b0;                                             // see R8
         else if (pll_lock_in)
            lock_ff <= 1'b1;                                             // see R8
      end
   end

   // -------------------------------------------------------------------
   // Tuning and pseudo-random trim registers
   // -------------------------------------------------------------------
   wire prt_fb = ~(prtrim_ff[14] ^ prtrim_ff[13]);    // Zero is not a lockup state
   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         tuning_ff    <= `OSC_RST_TUNING;
         tuning_up_ff <= `OSC_RST_TUNING;
         prtrim_ff    <= `OSC_RST_PRTRIM;
      end
      else
      begin
         if (wr_go & hit_tun & pstrb_in[0])
            tuning_ff[7:0] <= pwdata_in[7:0];
         if (wr_go & hit_tun & pstrb_in[1])
            tuning_ff[15:8] <= pwdata_in[15:8];
         if (wr_go & hit_tun_up & pstrb_in[0])
            tuning_up_ff[7:0] <= pwdata_in[7:0];
         if (wr_go & hit_tun_up & pstrb_in[1])
            tuning_up_ff[15:8] <= pwdata_in[15:8];
         // Software write wins over the dither step
         if (wr_go & hit_prt & (pstrb_in[1:0] != 2'h0))
         begin
            if (pstrb_in[0])
               prtrim_ff[7:0] <= pwdata_in[7:0];                         // see R19
            if (pstrb_in[1])
               prtrim_ff[14:8] <= pwdata_in[14:8];                       // see R19
         end
         else if (dither_ff)
            prtrim_ff <= {prtrim_ff[13:0], prt_fb};                      // see R10
      end
   end

   // -------------------------------------------------------------------
   // Trim selection
   // -------------------------------------------------------------------
   wire [31:0] seq_fields = {tuning_up_ff, tuning_ff};
   always @*
   begin
      sel_trim = tuning_ff[3:0];                                         // see R14
      if (tseq_ff)
         sel_trim = seq_fields[{roll_in, 2'h0} +: 4];                    // see R13, R15
   end

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         fast_rc_trim_out <= 4'h0;
         trim_step_out    <= 5'h00;
      end
      else if (dither_ff)
      begin
         fast_rc_trim_out <= prtrim_ff[3:0];
         trim_step_out    <= trim_step(prtrim_ff[3:0]);
      end
      else
      begin
         fast_rc_trim_out <= sel_trim;
         trim_step_out    <= trim_step(sel_trim);                        // see R16
      end
   end

   // -------------------------------------------------------------------
   // Read data, captured in the setup phase
   // -------------------------------------------------------------------
   always @*
   begin
      nxt_rdata = 32'h0000_0000;                                         // see R20
      if (hit_ctrl)
      begin
         nxt_rdata[`OSC_CUR_HI:`OSC_CUR_LO] = cur_grp_ff;                // see R1
         nxt_rdata[`OSC_NXT_HI:`OSC_NXT_LO] = nxt_grp_ff;
         nxt_rdata[`OSC_FREEZE_BIT]         = freeze_ff;
         nxt_rdata[`OSC_LOCK_BIT]           = lock_ff & cur_grp_ff[0];   // see R9
         nxt_rdata[`OSC_DITHER_BIT]         = dither_ff;
         nxt_rdata[`OSC_FAIL_BIT]           = fail_ff;                   // see R11
         nxt_rdata[`OSC_TSEQ_BIT]           = tseq_ff;
         nxt_rdata[`OSC_SWREQ_BIT]          = swreq_ff;
      end
      else if (hit_tun)
         nxt_rdata[15:0] = tuning_ff;
      else if (hit_tun_up)
         nxt_rdata[15:0] = tuning_up_ff;
      else if (hit_prt)
         nxt_rdata[14:0] = prtrim_ff;
   end

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         prdata_out <= 32'h0000_0000;
      else if (setup_ph)
         prdata_out <= nxt_rdata;
   end

endmodule // osc_ctrl

// ---- shared/osc_defs.vh ----
/*
 * Constants for the oscillator switch and trim control block: register
 * offsets, field positions, group codes, reset values and unlock bytes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OSC_OFF_CONTROL    12'h000
`define OSC_OFF_TUNING     12'h004
`define OSC_OFF_TUNING_UP  12'h008
`define OSC_OFF_PRTRIM     12'h00C

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define OSC_CUR_HI         14
`define OSC_CUR_LO         12
`define OSC_NXT_HI         10
`define OSC_NXT_LO         8
`define OSC_FREEZE_BIT     7
`define OSC_LOCK_BIT       5
`define OSC_DITHER_BIT     4
`define OSC_FAIL_BIT       3
`define OSC_TSEQ_BIT       2
`define OSC_SWREQ_BIT      0

// ----------------------------------------------------------------------
// Clock group codes
// ----------------------------------------------------------------------
`define OSC_GRP_FRC        3'h0
`define OSC_GRP_FRC_PLL    3'h1
`define OSC_GRP_PRI        3'h2
`define OSC_GRP_PRI_PLL    3'h3

// ----------------------------------------------------------------------
// Unlock bytes
// ----------------------------------------------------------------------
`define OSC_UNLK_LO_1      8'h46
`define OSC_UNLK_LO_2      8'h57
`define OSC_UNLK_HI_1      8'h78
`define OSC_UNLK_HI_2      8'h9A

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OSC_RST_TUNING     16'h0000
`define OSC_RST_PRTRIM     15'h0000

`endif

// ---- test/osc_ctrl_sva.sv ----
/*
 * Port checker for osc_ctrl: bus answer, switch sequencing, failure
 * fallback and trim step coding.
 * Assumes one clock clk_sys_in and synchronous active-high sys_rst_in.
 */
`timescale 1ns/100ps
module osc_ctrl_sva
(
   // Clock and reset
   input logic        clk_sys_in,
   input logic        sys_rst_in,
   // Bus
   input logic        psel_in,
   input logic        penable_in,
   input logic [11:0] paddr_in,
   input logic        pready_out,
   input logic        pslverr_out,
   // Configuration and oscillator status
   input logic [1:0]  switch_monitor_config_in,
   input logic        new_source_ready_in,
   input logic        pll_lock_in,
   input logic        clock_fail_in,
   // Clock control and trim
   input logic [2:0]  clk_sel_out,
   input logic [2:0]  target_group_out,
   input logic        source_start_out,
   input logic        clk_change_out,
   input logic [3:0]  fast_rc_trim_out,
   input logic [4:0]  trim_step_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   wire mapped = (paddr_in[11:4] == 8'h00) && (paddr_in[1:0] == 2'h0);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_rst;
      @(posedge clk_sys_in) disable iff (1'b0)
      sys_rst_in |=> clk_sel_out == 3'h0 && !source_start_out && !clk_change_out;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_unmapped;
      psel_in && penable_in && !mapped |-> pslverr_out;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
   property p_mapped;
      psel_in && penable_in && mapped |-> pready_out && !pslverr_out;
   endproperty
   a_mapped: assert property (p_mapped) else $error("bad answer on mapped");
   property p_step;
      trim_step_out == {fast_rc_trim_out[3], fast_rc_trim_out};
   endproperty
   a_step: assert property (p_step) else $error("trim step not sign extended");
   property p_hold;
      source_start_out && !new_source_ready_in && $past(!new_source_ready_in)
         && !clock_fail_in |=> $stable(clk_sel_out);
   endproperty
   a_hold: assert property (p_hold) else $error("clock moved before ready");
   property p_fail;
      clock_fail_in && switch_monitor_config_in == 2'h0
         |=> clk_sel_out == 3'h0 && !source_start_out;
   endproperty
   a_fail: assert property (p_fail) else $error("failure did not fall back");
   property p_nosw;
      !source_start_out && switch_monitor_config_in[1] |=> !source_start_out;
   endproperty
   a_nosw: assert property (p_nosw) else $error("switch while disabled");
   property p_chg_tgt;
      clk_change_out |-> clk_sel_out == target_group_out;
   endproperty
   a_chg_tgt: assert property (p_chg_tgt) else $error("change to wrong group");
   property p_chg_pulse;
      clk_change_out |=> !clk_change_out;
   endproperty
   a_chg_pulse: assert property (p_chg_pulse) else $error("change pulse too long");
   property p_chg_ready;
      clk_change_out |-> $past(new_source_ready_in, 2)
         && (!target_group_out[0] || $past(pll_lock_in, 2));
   endproperty
   a_chg_ready: assert property (p_chg_ready) else $error("change before ready");

   c_chg: cover property (clk_change_out);
   c_err: cover property (pslverr_out);
   c_fail: cover property (clock_fail_in && switch_monitor_config_in == 2'h0);
endmodule // osc_ctrl_sva

bind osc_ctrl osc_ctrl_sva u_sva
(
   .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .switch_monitor_config_in(switch_monitor_config_in),
   .new_source_ready_in(new_source_ready_in), .pll_lock_in(pll_lock_in),
   .clock_fail_in(clock_fail_in), .clk_sel_out(clk_sel_out),
   .target_group_out(target_group_out), .source_start_out(source_start_out),
   .clk_change_out(clk_change_out), .fast_rc_trim_out(fast_rc_trim_out),
   .trim_step_out(trim_step_out)
);

// ---- test/osc_ctrl_tb_top.sv ----
/*
 * Testbench for osc_ctrl: register access, trim selection, switching,
 * failure fallback, freeze and start-up group.
 * Assumes the checker is bound in and the bus answers as handed over.
 */
`timescale 1ns/100ps
module osc_ctrl_tb_top;
   logic        clk_sys_in, sys_rst_in, psel_in, penable_in, pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, comb;
   logic [3:0]  pstrb_in, fast_rc_trim_out, f;
   logic        pready_out, pslverr_out, new_source_ready_in, pll_lock_in;
   logic        clock_fail_in, source_start_out, clk_change_out;
   logic [1:0]  cfg_initial_group_in, switch_monitor_config_in;
   logic [2:0]  roll_in, clk_sel_out, target_group_out;
   logic [4:0]  trim_step_out;
   logic [14:0] p;
   logic [31:0] exp_q[$];
   int          err_count, check_count;

   osc_ctrl uut
   (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out),
      .prdata_out(prdata_out), .pslverr_out(pslverr_out),
      .cfg_initial_group_in(cfg_initial_group_in),
      .switch_monitor_config_in(switch_monitor_config_in),
      .new_source_ready_in(new_source_ready_in), .pll_lock_in(pll_lock_in),
      .clock_fail_in(clock_fail_in), .roll_in(roll_in), .clk_sel_out(clk_sel_out),
      .target_group_out(target_group_out), .source_start_out(source_start_out),
      .clk_change_out(clk_change_out), .fast_rc_trim_out(fast_rc_trim_out),
      .trim_step_out(trim_step_out)
   );

   initial
   begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic close_out;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      pstrb_in <= s;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do @(posedge clk_sys_in); while (pready_out !== 1'b1);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask

   task automatic wb(input logic hi, input logic [7:0] v);
      apb(1'b1, 12'h000, hi ? {16'h0, v, 8'h00} : {24'h0, v}, hi ? 4'h2 : 4'h1);
   endtask

   // Control byte write behind its two unlock bytes
   task automatic unl(input logic hi, input logic [7:0] v);
      wb(hi, hi ? 8'h78 : 8'h46);
      wb(hi, hi ? 8'h9A : 8'h57);
      wb(hi, v);
   endtask

   task automatic do_rst;
      sys_rst_in <= 1'b1;
      repeat (16) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
   endtask

   task automatic wait_chg;
      int n;
      n = 0;
      while (clk_change_out !== 1'b1 && n < 100)
      begin
         @(posedge clk_sys_in);
         n++;
      end
      chk(32'(clk_change_out), 32'h1);
   endtask

   // Read data monitor
   always @(posedge clk_sys_in)
   begin
      if (psel_in && penable_in && pready_out && !pwrite_in)
         chk(prdata_out, exp_q.pop_front());
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys_in);
      err_count++;
      close_out;
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'hDE9A));
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} = '0;
      {cfg_initial_group_in, switch_monitor_config_in, roll_in} = '0;
      {new_source_ready_in, pll_lock_in, clock_fail_in} = '0;
      sys_rst_in = 1'b1;
      do_rst;
      rd(12'h000, 32'h0);
      rd(12'h00C, 32'h0);
      rd(12'h010, 32'h0);
      comb = $urandom();
      apb(1'b1, 12'h004, comb, 4'hF);
      apb(1'b1, 12'h008, {comb[15:0], comb[31:16]}, 4'hF);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF, 4'hF);
      rd(12'h004, {16'h0, comb[15:0]});
      rd(12'h008, {16'h0, comb[31:16]});
      rd(12'h00C, 32'h7FFF);
      apb(1'b1, 12'h00C, 32'h1234, 4'h3);
      unl(1'b0, 8'h10);
      repeat (2) @(posedge clk_sys_in);
      chk(32'(fast_rc_trim_out), 32'h4);
      unl(1'b0, 8'h00);
      p = 15'h1234;
      repeat (11) p = {p[13:0], ~(p[14] ^ p[13])};
      rd(12'h00C, {17'h0, p});
      for (int r = 0; r < 8; r++)
      begin
         roll_in <= r[2:0];
         repeat (2) @(posedge clk_sys_in);
         chk(32'(fast_rc_trim_out), 32'(comb[3:0]));
      end
      unl(1'b0, 8'h46);
      rd(12'h000, 32'h4);
      wb(1'b0, 8'h01);
      rd(12'h000, 32'h4);
      for (int r = 0; r < 8; r++)
      begin
         roll_in <= r[2:0];
         repeat (2) @(posedge clk_sys_in);
         f = comb[4*r +: 4];
         chk(32'(fast_rc_trim_out), 32'(f));
         chk(32'(trim_step_out), 32'({f[3], f}));
      end
      unl(1'b1, 8'h03);
      rd(12'h000, 32'h0304);
      new_source_ready_in <= 1'b1;
      unl(1'b0, 8'h05);
      repeat (6) @(posedge clk_sys_in);
      chk(32'(clk_sel_out), 32'h0);
      pll_lock_in <= 1'b1;
      wait_chg;
      chk(32'(clk_sel_out), 32'h3);
      rd(12'h000, 32'h3324);
      pll_lock_in <= 1'b0;
      rd(12'h000, 32'h3304);
      unl(1'b0, 8'h05);
      rd(12'h000, 32'h3304);
      {clock_fail_in, pll_lock_in} <= 2'h3;
      @(posedge clk_sys_in);
      clock_fail_in <= 1'b0;
      rd(12'h000, 32'h030C);
      chk(32'(clk_sel_out), 32'h0);
      unl(1'b0, 8'h04);
      rd(12'h000, 32'h0304);
      switch_monitor_config_in <= 2'h1;
      clock_fail_in <= 1'b1;
      rd(12'h000, 32'h0304);
      clock_fail_in <= 1'b0;
      switch_monitor_config_in <= 2'h2;
      unl(1'b0, 8'h84);
      unl(1'b1, 8'h02);
      unl(1'b0, 8'h05);
      rd(12'h000, 32'h0384);
      cfg_initial_group_in <= 2'h2;
      switch_monitor_config_in <= 2'h0;
      do_rst;
      wait_chg;
      rd(12'h000, 32'h2200);
      close_out;
   end
endmodule // osc_ctrl_tb_top
